/* File: rtl/crf_core.sv */
module crf_core (
  input wire logic core_clk, // CPU clock
  input wire logic resetn, // Async reset, active low
  input wire logic [4:0] rd_a_sel, // First 8-bit operand select
  input wire logic [4:0] rd_b_sel, // Second 8-bit operand select
  input wire logic rd_wide, // Read pair at rd_a_sel as 16 bits
  output logic [7:0] rd_a_data, // First operand
  output logic [7:0] rd_b_data, // Second operand
  output logic [15:0] rd_wide_data, // 16-bit operand
  input wire logic [4:0] wr_sel, // Result destination
  input wire crf_pkg::crf_alu_t alu_in, // ALU result and flags
  input wire logic [1:0] ptr_sel, // Pointer 0..2
  input wire logic ptr_step, // Apply pointer mode
  input wire crf_pkg::crf_ptr_mode_t ptr_mode, // Pointer mode
  input wire logic [5:0] ptr_disp, // Fixed displacement
  output logic [15:0] ptr_addr, // Effective pointer address
  input wire crf_pkg::crf_sp_op_t sp_op, // Stack adjustment
  output logic [15:0] stack_ptr, // Current stack pointer
  input wire logic ext_read, // Extended program read select
  output logic [23:0] prog_addr, // Program memory byte address
  input wire crf_pkg::crf_mem_t mem_in, // Software access
  output logic [7:0] mem_rdata, // Read data
  output logic mem_hit // Access hit this block
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [7:0] gpr [32];
  logic [7:0] status_flags;
  logic [7:0] flash_page_extension;
  logic [7:0] sp_temp;
  logic [15:0] next_sp;
  logic [15:0] next_ptr;
  logic [15:0] ptr_val;
  logic [4:0] ptr_low;
  logic [15:0] daddr;
  logic gpr_hit;
  logic io_hit;
  logic [7:0] io_addr;
  logic minus;
  logic [7:0] next_flags;
  logic wr_flags;
  logic wr_sp_low;
  logic wr_sp_high;
  logic wr_ext;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // I/O accesses are shifted into data space; extended I/O never is
  always_comb begin
    io_addr = mem_in.addr[7:0];
    if (mem_in.io) begin
      io_addr = mem_in.addr[7:0] + crf_pkg::IO_OFFSET;
    end
    daddr = mem_in.io ? {8'h00, io_addr} : mem_in.addr;
  end

  assign gpr_hit = !mem_in.io
    && (daddr <= {8'h00, crf_pkg::GPR_LAST});
  assign io_hit = (mem_in.io && (mem_in.addr <= {8'h00, crf_pkg::IO_LAST}))
    || (!mem_in.io && daddr > {8'h00, crf_pkg::GPR_LAST}
    && daddr < {8'h00, crf_pkg::EXT_IO_BASE});

  // Write strobes; both address spaces meet here on the data address
  assign wr_flags = mem_in.wr && io_hit
    && daddr[7:0] == crf_pkg::ADDR_FLAGS;
  assign wr_sp_low = mem_in.wr && io_hit
    && daddr[7:0] == crf_pkg::ADDR_SP_LOW;
  assign wr_sp_high = mem_in.wr && io_hit
    && daddr[7:0] == crf_pkg::ADDR_SP_HIGH;
  assign wr_ext = mem_in.wr && io_hit
    && daddr[7:0] == crf_pkg::ADDR_EXT;

  // ------------------------------------------------------------------
  // Pointer arithmetic
  // ------------------------------------------------------------------
  always_comb begin
    ptr_low = 5'(crf_pkg::PTR_A_LOW + 5'({ptr_sel, 1'b0}));
    ptr_val = {gpr[ptr_low + 5'h01], gpr[ptr_low]};
    next_ptr = ptr_val;
    ptr_addr = ptr_val;
    case (ptr_mode)
      crf_pkg::CRF_PM_DISP: ptr_addr = ptr_val + {10'h000, ptr_disp};
      crf_pkg::CRF_PM_POSTINC: next_ptr = ptr_val + 16'h0001;
      crf_pkg::CRF_PM_PREDEC: begin
        next_ptr = ptr_val - 16'h0001;
        ptr_addr = next_ptr;
      end
      default: ptr_addr = ptr_val;
    endcase
  end

  // Extended reads and stores prepend the page byte; plain reads do not
  assign prog_addr = ext_read
    ? {flash_page_extension, gpr[crf_pkg::PTR_C_LOW + 5'h01],
       gpr[crf_pkg::PTR_C_LOW]}
    : {8'h00, gpr[crf_pkg::PTR_C_LOW + 5'h01],
       gpr[crf_pkg::PTR_C_LOW]};

  // ------------------------------------------------------------------
  // Register file writes
  // ------------------------------------------------------------------
  // Priority: ALU result, then software store, then pointer update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= 8'h00;
      end
    end else begin
      if (ptr_step && ptr_mode != crf_pkg::CRF_PM_DISP) begin
        gpr[ptr_low] <= next_ptr[7:0];
        gpr[ptr_low + 5'h01] <= next_ptr[15:8];
      end
      if (mem_in.wr && gpr_hit) begin
        gpr[daddr[4:0]] <= mem_in.wdata;
      end
      if (alu_in.valid && alu_in.wide) begin
        gpr[{wr_sel[4:1], 1'b0}] <= alu_in.result16[7:0];
        gpr[{wr_sel[4:1], 1'b1}] <= alu_in.result16[15:8];
      end else if (alu_in.valid) begin
        gpr[wr_sel] <= alu_in.result;
      end
    end
  end

  // Operand ports; the wide port reads an aligned pair
  always_comb begin
    rd_a_data = gpr[rd_a_sel];
    rd_b_data = gpr[rd_b_sel];
    rd_wide_data = rd_wide ? {gpr[{rd_a_sel[4:1], 1'b1}],
      gpr[{rd_a_sel[4:1], 1'b0}]} : 16'h0000;
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  always_comb begin
    next_flags = status_flags;
    minus = alu_in.wide ? alu_in.result16[15] : alu_in.result[7];
    next_flags[crf_pkg::FLAG_N] = minus;
    next_flags[crf_pkg::FLAG_Z] = alu_in.wide
      ? (alu_in.result16 == 16'h0000)
      : (alu_in.result == 8'h00);
    next_flags[crf_pkg::FLAG_C] = alu_in.carry;
    next_flags[crf_pkg::FLAG_V] = alu_in.overflow;
    next_flags[crf_pkg::FLAG_S] = minus ^ alu_in.overflow;
  end

  // Flags are never stacked by hardware on interrupt entry
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_flags <= crf_pkg::FLAGS_RESET;
    end else if (alu_in.valid) begin
      status_flags <= next_flags;
    end else if (wr_flags) begin
      status_flags <= {mem_in.wdata[7:5],
        mem_in.wdata[crf_pkg::FLAG_N] ^ mem_in.wdata[crf_pkg::FLAG_V],
        mem_in.wdata[3:0]};
    end
  end

  // ------------------------------------------------------------------
  // Stack pointer
  // ------------------------------------------------------------------
  always_comb begin
    case (sp_op)
      crf_pkg::CRF_SP_PUSH: next_sp = stack_ptr - 16'h0001;
      crf_pkg::CRF_SP_POP: next_sp = stack_ptr + 16'h0001;
      crf_pkg::CRF_SP_CALL: next_sp = stack_ptr - 16'h0002;
      crf_pkg::CRF_SP_RET: next_sp = stack_ptr + 16'h0002;
      default: next_sp = stack_ptr;
    endcase
  end

  // Low byte write only fills the latch; high byte write commits both
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stack_ptr <= crf_pkg::SP_RESET;
    end else if (wr_sp_high) begin
      stack_ptr <= {mem_in.wdata, sp_temp}
        & crf_pkg::SP_MASK;
    end else begin
      stack_ptr <= next_sp & crf_pkg::SP_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sp_temp <= 8'h00;
    end else if (wr_sp_low) begin
      sp_temp <= mem_in.wdata;
    end
  end

  // ------------------------------------------------------------------
  // Page extension byte
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flash_page_extension <= crf_pkg::EXT_RESET;
    end else if (wr_ext) begin
      flash_page_extension <= mem_in.wdata & crf_pkg::EXT_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Read data, registered
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_rdata <= 8'h00;
      mem_hit <= 1'b0;
    end else begin
      mem_hit <= (mem_in.rd || mem_in.wr) && (gpr_hit || io_hit);
      mem_rdata <= 8'h00;
      if (mem_in.rd && gpr_hit) begin
        mem_rdata <= gpr[daddr[4:0]];
      end else if (mem_in.rd && io_hit) begin
        case (daddr[7:0])
          crf_pkg::ADDR_FLAGS: mem_rdata <= status_flags;
          crf_pkg::ADDR_SP_LOW: mem_rdata <= stack_ptr[7:0];
          crf_pkg::ADDR_SP_HIGH: mem_rdata <= stack_ptr[15:8];
          crf_pkg::ADDR_EXT: mem_rdata <= flash_page_extension
            & crf_pkg::EXT_MASK;
          default: mem_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Flag bits after an ALU result
  a_sign_flag: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $past(alu_in.valid) |-> status_flags[crf_pkg::FLAG_S] ==
      (status_flags[crf_pkg::FLAG_N] ^ status_flags[crf_pkg::FLAG_V]))
    else $error("sign flag mismatch");
  a_ovf_flag: assert property (@(posedge core_clk)
    disable iff (!resetn)
    alu_in.valid |=> status_flags[crf_pkg::FLAG_V] == $past(alu_in.overflow))
    else $error("overflow flag wrong");
  a_neg_flag: assert property (@(posedge core_clk)
    disable iff (!resetn)
    alu_in.valid && !alu_in.wide |=> status_flags[crf_pkg::FLAG_N] ==
      $past(alu_in.result[7]))
    else $error("negative flag wrong");
  a_zero_flag: assert property (@(posedge core_clk)
    disable iff (!resetn)
    alu_in.valid && !alu_in.wide |=> status_flags[crf_pkg::FLAG_Z] ==
      ($past(alu_in.result) == 8'h00))
    else $error("zero flag wrong");
  a_carry_flag: assert property (@(posedge core_clk)
    disable iff (!resetn)
    alu_in.valid |=> status_flags[crf_pkg::FLAG_C] == $past(alu_in.carry))
    else $error("carry flag wrong");
  // Flags must not drift between results; software saves them itself
  a_flags_hold: assert property (@(posedge core_clk)
    disable iff (!resetn)
    !alu_in.valid && !wr_flags |=> $stable(status_flags))
    else $error("flags moved without cause");

  // Stack pointer steps and the two-byte commit
  a_sp_push: assert property (@(posedge core_clk)
    disable iff (!resetn)
    sp_op == crf_pkg::CRF_SP_PUSH && !mem_in.wr |=>
      stack_ptr == (($past(stack_ptr) - 16'h0001) & crf_pkg::SP_MASK))
    else $error("push step wrong");
  a_sp_pop: assert property (@(posedge core_clk)
    disable iff (!resetn)
    sp_op == crf_pkg::CRF_SP_POP && !mem_in.wr |=>
      stack_ptr == (($past(stack_ptr) + 16'h0001) & crf_pkg::SP_MASK))
    else $error("pop step wrong");
  a_sp_call: assert property (@(posedge core_clk)
    disable iff (!resetn)
    sp_op == crf_pkg::CRF_SP_CALL && !mem_in.wr |=>
      stack_ptr == (($past(stack_ptr) - 16'h0002) & crf_pkg::SP_MASK))
    else $error("call step wrong");
  a_sp_ret: assert property (@(posedge core_clk)
    disable iff (!resetn)
    sp_op == crf_pkg::CRF_SP_RET && !mem_in.wr |=>
      stack_ptr == (($past(stack_ptr) + 16'h0002) & crf_pkg::SP_MASK))
    else $error("return step wrong");
  a_sp_latch: assert property (@(posedge core_clk)
    disable iff (!resetn)
    wr_sp_low && sp_op == crf_pkg::CRF_SP_HOLD |=> $stable(stack_ptr))
    else $error("low byte moved stack pointer");
  a_sp_commit: assert property (@(posedge core_clk)
    disable iff (!resetn)
    wr_sp_high |=> stack_ptr ==
      ({$past(mem_in.wdata), $past(sp_temp)} & crf_pkg::SP_MASK))
    else $error("high byte commit wrong");

  // Register file and program address forming
  a_gpr_store: assert property (@(posedge core_clk)
    disable iff (!resetn)
    mem_in.wr && gpr_hit && !alu_in.valid && !ptr_step |=>
      gpr[$past(daddr[4:0])] == $past(mem_in.wdata))
    else $error("data store missed register");
  a_prog_plain: assert property (@(posedge core_clk)
    disable iff (!resetn)
    !ext_read |-> prog_addr[23:16] == 8'h00)
    else $error("plain read used page byte");
  a_prog_ext: assert property (@(posedge core_clk)
    disable iff (!resetn)
    ext_read |-> prog_addr[23:16] == flash_page_extension)
    else $error("extended read lost page byte");
  a_wide_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    alu_in.valid && alu_in.wide |=>
      {gpr[{$past(wr_sel[4:1]), 1'b1}], gpr[{$past(wr_sel[4:1]), 1'b0}]}
        == $past(alu_in.result16))
    else $error("wide result not written");

endmodule // crf_core

/* File: rtl/crf_pkg.sv */
//----------------------------------------------------------------------
// Function
// - Sign flag is minus xor overflow
// - Bit 3 holds two's complement overflow
// - Bit 2 set on negative result
// - Bit 1 set on zero result
// - Bit 0 set on carry out
// - Four operand/result port schemes supported
// - General registers alias data addresses 0x00-0x1F
// - Pointers may address general registers
// - Top six registers form three pointers
// - Pointer displacement, post-increment, pre-decrement
// - Byte push decrements, byte pop increments
// - Calls and interrupt entry subtract two
// - Returns add two to stack pointer
// - Pop increments stack pointer by one
// - Stack pointer tracks top of stack
// - Stack pointer resets to 0x10FF
// - Stack pointer low/high at base, base+1
// - I/O address plus 0x20 gives data address
// - Extended I/O only via data space
// - Extended read/store use extension:pointer_c
// - Plain program read ignores extension byte
// - Unimplemented extension bits read zero
// - Flags update after every ALU operation
// - 16-bit write: low to latch, high commits
//----------------------------------------------------------------------
package crf_pkg;

  // ------------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------------
  localparam logic [7:0] GPR_LAST = 8'h1F;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;
  localparam logic [7:0] ADDR_EXT = 8'h5B;
  localparam logic [7:0] ADDR_SP_LOW = 8'h5D;
  localparam logic [7:0] ADDR_SP_HIGH = 8'h5E;
  localparam logic [7:0] ADDR_FLAGS = 8'h5F;
  localparam logic [4:0] PTR_A_LOW = 5'h1A;
  localparam logic [4:0] PTR_B_LOW = 5'h1C;
  localparam logic [4:0] PTR_C_LOW = 5'h1E;

  // ------------------------------------------------------------------
  // Field positions and resets
  // ------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam logic [15:0] SP_RESET = 16'h10FF;
  localparam logic [15:0] SP_MASK = 16'h1FFF;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] EXT_MASK = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Stack pointer adjustments
  typedef enum logic [2:0] {
    CRF_SP_HOLD = 3'h0, CRF_SP_PUSH = 3'h1, CRF_SP_POP = 3'h2,
    CRF_SP_CALL = 3'h3, CRF_SP_RET = 3'h4
  } crf_sp_op_t;

  // Pointer addressing modes
  typedef enum logic [1:0] {
    CRF_PM_DISP = 2'h0, CRF_PM_POSTINC = 2'h1, CRF_PM_PREDEC = 2'h2
  } crf_ptr_mode_t;

  // ALU result with flags
  typedef struct packed {
    logic valid;
    logic [7:0] result;
    logic carry;
    logic overflow;
    logic wide;
    logic [15:0] result16;
  } crf_alu_t;

  // Software data-space access
  typedef struct packed {
    logic rd;
    logic wr;
    logic io;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crf_mem_t;

endpackage : crf_pkg

/* File: verif/crf_core_bench.sv */
module crf_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus, observed outputs and reference state
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] rd_a_sel = 5'h00;
  logic [4:0] rd_b_sel = 5'h00;
  logic rd_wide = 1'b0;
  logic [4:0] wr_sel = 5'h00;
  logic [1:0] ptr_sel = 2'h0;
  logic ptr_step = 1'b0;
  logic [5:0] ptr_disp = 6'h00;
  logic ext_read = 1'b0;
  crf_pkg::crf_alu_t alu_in = '0;
  crf_pkg::crf_ptr_mode_t ptr_mode = crf_pkg::CRF_PM_DISP;
  crf_pkg::crf_sp_op_t sp_op = crf_pkg::CRF_SP_HOLD;
  crf_pkg::crf_mem_t mem_in = '0;
  logic [7:0] rd_a_data, rd_b_data, mem_rdata;
  logic [15:0] rd_wide_data, ptr_addr, stack_ptr;
  logic [23:0] prog_addr;
  logic mem_hit;
  logic [7:0] gpr [32];
  logic [15:0] sp_m = 16'h10FF;
  logic [15:0] pv;
  logic [7:0] flg = 8'h00;
  int bad_count = 0;
  int n_compared = 0;

  // Free-running CPU clock, 4 ns period
  always #2 core_clk = ~core_clk;

  crf_core i_dut (
    .core_clk(core_clk), .resetn(resetn), .rd_a_sel(rd_a_sel),
    .rd_b_sel(rd_b_sel), .rd_wide(rd_wide), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .rd_wide_data(rd_wide_data), .wr_sel(wr_sel),
    .alu_in(alu_in), .ptr_sel(ptr_sel), .ptr_step(ptr_step),
    .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr),
    .sp_op(sp_op), .stack_ptr(stack_ptr), .ext_read(ext_read),
    .prog_addr(prog_addr), .mem_in(mem_in), .mem_rdata(mem_rdata),
    .mem_hit(mem_hit)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One software access; read data stands only in the cycle after
  task automatic mem(input logic wr, input logic io, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    mem_in <= '{rd: ~wr, wr: wr, io: io, addr: a, wdata: d};
    @(posedge core_clk);
    mem_in <= '0;
    #1;
    if (wr && !io && a < 16'h0020) begin
      gpr[a[4:0]] = d;
    end
  endtask

  task automatic rdchk(input logic io, input logic [15:0] a,
                       input logic [7:0] e, input logic hit);
    mem(1'b0, io, a, 8'h00);
    chk({mem_hit, mem_rdata}, {hit, e});
  endtask

  // Single ALU result; reference flags keep the upper three bits
  task automatic alu(input logic [4:0] r, input logic [15:0] v,
                     input logic c, input logic o, input logic w);
    @(posedge core_clk);
    wr_sel <= r;
    rd_a_sel <= r;
    rd_b_sel <= r ^ 5'h01;
    rd_wide <= w;
    alu_in <= '{valid: 1'b1, result: v[7:0], carry: c, overflow: o,
                wide: w, result16: v};
    @(posedge core_clk);
    alu_in <= '0;
    #1;
    if (w) begin
      gpr[r | 5'h01] = v[15:8];
      gpr[r & 5'h1E] = v[7:0];
      flg = {flg[7:5], v[15] ^ o, o, v[15], v == 16'h0000, c};
    end else begin
      gpr[r] = v[7:0];
      flg = {flg[7:5], v[7] ^ o, o, v[7], v[7:0] == 8'h00, c};
    end
  endtask

  task automatic spop(input crf_pkg::crf_sp_op_t op, input int dlt);
    @(posedge core_clk);
    sp_op <= op;
    @(posedge core_clk);
    sp_op <= crf_pkg::CRF_SP_HOLD;
    #1;
    // Bits 15:13 are not implemented and always read as zero
    sp_m = (sp_m + 16'(dlt)) & 16'h1FFF;
    chk(stack_ptr, sp_m);
  endtask

  // Address is checked before the step edge, while the mode is applied
  task automatic pstep(input logic [1:0] p, input crf_pkg::crf_ptr_mode_t m,
                       input logic [5:0] d, input logic s,
                       input logic [15:0] e);
    @(posedge core_clk);
    ptr_sel <= p;
    ptr_mode <= m;
    ptr_disp <= d;
    ptr_step <= s;
    #1;
    chk(ptr_addr, e);
    @(posedge core_clk);
    ptr_step <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] h;
    logic [4:0] r;
    foreach (gpr[i]) gpr[i] = 8'h00;
    void'($urandom(15631));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk(stack_ptr, sp_m);
    rdchk(1'b0, 16'h005D, 8'hFF, 1'b1);
    rdchk(1'b0, 16'h005E, 8'h10, 1'b1);
    rdchk(1'b1, 16'h003D, 8'hFF, 1'b1);
    rdchk(1'b0, 16'h005B, 8'h00, 1'b1);
    rdchk(1'b0, 16'h0060, 8'h00, 1'b0);
    spop(crf_pkg::CRF_SP_PUSH, -1);
    spop(crf_pkg::CRF_SP_CALL, -2);
    spop(crf_pkg::CRF_SP_RET, 2);
    spop(crf_pkg::CRF_SP_POP, 1);
    // Low byte alone must not move the pointer until the high byte lands
    v = 8'($urandom);
    h = 8'($urandom) & 8'h1F;
    mem(1'b1, 1'b0, 16'h005D, v);
    chk(stack_ptr, sp_m);
    mem(1'b1, 1'b1, 16'h003E, h);
    sp_m = {h, v};
    chk(stack_ptr, sp_m);
    spop(crf_pkg::CRF_SP_CALL, -2);
    // Written sign bit is overridden by the minus/overflow relation
    mem(1'b1, 1'b0, 16'h005F, 8'hBC);
    flg = 8'hAC;
    rdchk(1'b1, 16'h003F, flg, 1'b1);
    for (int i = 0; i < 24; i++) begin
      r = 5'($urandom);
      v = (i == 0) ? 8'h00 : 8'($urandom);
      alu(r, {8'h00, v}, 1'($urandom), 1'($urandom), 1'b0);
      chk(rd_a_data, gpr[r]);
      chk(rd_b_data, gpr[r ^ 5'h01]);
      chk(rd_wide_data, 16'h0000);
      rdchk(1'b1, 16'h003F, flg, 1'b1);
      rdchk(1'b0, 16'h005F, flg, 1'b1);
      rdchk(1'b0, {11'h000, r}, gpr[r], 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      r = 5'($urandom) & 5'h1E;
      alu(r, 16'($urandom), 1'b0, 1'b0, 1'b1);
      chk(rd_wide_data, {gpr[r + 5'h01], gpr[r]});
      chk(rd_b_data, gpr[r + 5'h01]);
      rdchk(1'b1, 16'h003F, flg, 1'b1);
    end
    // Each pointer through every addressing mode; net movement is zero
    for (int p = 0; p < 3; p++) begin
      mem(1'b1, 1'b0, 16'h001A + 16'(2 * p), 8'($urandom));
      mem(1'b1, 1'b0, 16'h001B + 16'(2 * p), 8'($urandom));
      pv = {gpr[27 + 2 * p], gpr[26 + 2 * p]};
      h = 8'($urandom) & 8'h3F;
      pstep(2'(p), crf_pkg::CRF_PM_DISP, 6'(h), 1'b0,
            pv + 16'(h));
      pstep(2'(p), crf_pkg::CRF_PM_POSTINC, 6'h00, 1'b1, pv);
      pv = pv + 16'h0001;
      pstep(2'(p), crf_pkg::CRF_PM_PREDEC, 6'h00, 1'b1,
            pv - 16'h0001);
      pv = pv - 16'h0001;
      pstep(2'(p), crf_pkg::CRF_PM_DISP, 6'h00, 1'b0, pv);
    end
    v = 8'($urandom);
    mem(1'b1, 1'b0, 16'h005B, v);
    rdchk(1'b1, 16'h003B, v, 1'b1);
    pv = {gpr[31], gpr[30]};
    @(posedge core_clk);
    ext_read <= 1'b1;
    #1;
    chk(prog_addr, {v, pv});
    @(posedge core_clk);
    ext_read <= 1'b0;
    #1;
    chk(prog_addr, {8'h00, pv});
    conclude();
  end

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule // crf_core_bench
